// file: usc_core.sv
/*
  Physical-layer end of the controller service link: transmit and receive
  start/end handshakes, octet handshakes and the receive vector, with an
  APB register file through which modem firmware reports air events.
  Assumes the controller logic and the APB master share pclk.
*/
// Design decisions made here: the APB register port and the address map.
`timescale 1ns/1ps
module usc_core (
  input wire logic pclk,
  input wire logic presetn,
  input usc_pkg::usc_apb_req_s apb_req,
  output usc_pkg::usc_apb_rsp_s apb_rsp,
  input usc_pkg::usc_mac_s mac,
  output usc_pkg::usc_phy_s phy
);
  import usc_pkg::*;

  // ==========================================================================
  // State
  usc_core_s r_reg;
  usc_core_s r_next;
  usc_rxv_s rx_vec;
  logic [ST_W-1:0] st_set;
  logic [ST_W-1:0] st_clr;
  logic [ST_W-1:0] st_q;
  logic wr;
  logic rd_setup;
  logic [4:0] ev;
  logic rx_push;
  logic rx_refused;
  logic rx_timeout;
  logic in_rx;

  // ==========================================================================
  // APB decode
  always_comb begin
    wr = apb_req.psel & apb_req.penable & apb_req.pwrite;
    rd_setup = apb_req.psel & ~apb_req.penable;
    ev = (wr && apb_req.paddr == CTRL_OFS) ? apb_req.pwdata[4:0] : 5'h00;
    rx_push = wr && apb_req.paddr == RXOCT_OFS;
    rx_timeout = ev[EV_TIMEOUT] && (r_reg.state == ST_RX_ACQ || r_reg.state == ST_RX_HDR);
    in_rx = r_reg.state == ST_RX_ACQ || r_reg.state == ST_RX_HDR || r_reg.state == ST_RX_DATA;
    rx_refused = rx_push && (r_reg.state != ST_RX_DATA || r_reg.rx_busy);
  end

  usc_rxv_pack u_rxv (
    .rxinfo(r_reg.rxinfo),
    .rxqual(r_reg.rxqual),
    .hdr(r_reg.hdr),
    .timeout(rx_timeout),
    .vec(rx_vec)
  );

  // ==========================================================================
  // Status flags
  always_comb begin
    st_set = '0;
    st_set[0] = mac.tx_start_req;
    st_set[1] = mac.tx_end_req;
    st_set[2] = mac.rx_start_req;
    st_set[3] = mac.rx_end_req;
    st_set[4] = mac.octet_tx_req;
    st_set[5] = mac.octet_rx_rsp;
    st_set[6] = rx_refused;
    st_clr = (wr && apb_req.paddr == STATUS_OFS) ? apb_req.pwdata[ST_W-1:0] : '0;
  end

  usc_sticky #(.W(ST_W)) u_status (
    .pclk(pclk),
    .presetn(presetn),
    .set(st_set),
    .clr(st_clr),
    .q(st_q)
  );

  // ==========================================================================
  // Sequencer and register file
  always_comb begin
    r_next = r_reg;
    r_next.phy.tx_start_cfm = 1'b0;
    r_next.phy.tx_end_cfm = 1'b0;
    r_next.phy.rx_start_cfm = 1'b0;
    r_next.phy.rx_sync_ind = 1'b0;
    r_next.phy.rx_done_ind = 1'b0;
    r_next.phy.rx_end_cfm = 1'b0;
    r_next.phy.octet_tx_cfm = 1'b0;
    r_next.phy.octet_rx_ind = 1'b0;

    // Register writes
    if (wr) begin
      unique case (apb_req.paddr)
        RXINFO_OFS: r_next.rxinfo = apb_req.pwdata;
        RXQUAL_OFS: r_next.rxqual = apb_req.pwdata[23:0];
        RXHDR0_OFS: r_next.hdr[31:0] = apb_req.pwdata;
        RXHDR1_OFS: r_next.hdr[63:32] = apb_req.pwdata;
        RXHDR2_OFS: r_next.hdr[79:64] = apb_req.pwdata[15:0];
        default: ;
      endcase
    end

    unique case (r_reg.state)
      ST_IDLE: begin
        if (mac.tx_start_req) begin
          r_next.txv = mac.tx_param_vector;
          r_next.tx_count = 16'h0000;
          r_next.state = ST_TX_PRE;
        end else if (mac.rx_start_req) begin
          r_next.state = ST_RX_ACQ;
        end
      end
      ST_TX_PRE: begin
        // Confirm once the firmware reports the preamble on air
        if (ev[EV_PRE_SENT]) begin
          r_next.phy.tx_start_cfm = 1'b1;
          r_next.state = ST_TX_DATA;
        end
      end
      ST_TX_DATA: begin
        if (mac.octet_tx_req) begin
          r_next.phy.octet_tx_cfm = 1'b1;
          r_next.tx_last = mac.octet_tx_data;
          r_next.tx_count = r_reg.tx_count + 16'h0001;
        end
        if (mac.tx_end_req) begin
          r_next.phy.tx_end_cfm = 1'b1;
          r_next.state = ST_IDLE;
        end
      end
      ST_RX_ACQ: begin
        if (ev[EV_SYNC]) begin
          r_next.phy.rx_sync_ind = 1'b1;
          r_next.state = ST_RX_HDR;
        end
      end
      ST_RX_HDR: begin
        if (ev[EV_HDR_DONE]) begin
          r_next.state = ST_RX_DATA;
        end
      end
      ST_RX_DATA: begin
        if (rx_push && !r_reg.rx_busy) begin
          r_next.phy.octet_rx_ind = 1'b1;
          r_next.phy.octet_rx_data = apb_req.pwdata[7:0];
          r_next.rx_busy = 1'b1;
        end
        if (ev[EV_PKT_DONE]) begin
          r_next.phy.rx_done_ind = 1'b1;
        end
      end
    endcase

    // Header complete or timed out: confirm with the vector
    if ((r_reg.state == ST_RX_HDR && ev[EV_HDR_DONE]) || rx_timeout) begin
      r_next.phy.rx_start_cfm = 1'b1;
      r_next.phy.rx_param_vector = rx_vec;
      r_next.state = ST_RX_DATA;
    end
    if (mac.octet_rx_rsp) begin
      r_next.rx_busy = 1'b0;
    end

    // Abort or finish of reception from any receive state
    if (in_rx && mac.rx_end_req) begin
      r_next.phy.rx_end_cfm = 1'b1;
      r_next.rx_busy = 1'b0;
      r_next.state = ST_IDLE;
    end

    // Read data is captured in the setup phase
    if (rd_setup) begin
      r_next.prdata = 32'h0000_0000;
      r_next.pslverr = 1'b0;
      unique case (apb_req.paddr)
        CTRL_OFS: r_next.prdata = 32'h0000_0000;
        STATUS_OFS: begin
          r_next.prdata[ST_W-1:0] = st_q;
          r_next.prdata[STATE_POS +: 3] = r_reg.state;
          r_next.prdata[BUSY_POS] = r_reg.rx_busy;
        end
        RXINFO_OFS: r_next.prdata = r_reg.rxinfo;
        RXQUAL_OFS: r_next.prdata = {8'h00, r_reg.rxqual};
        RXHDR0_OFS: r_next.prdata = r_reg.hdr[31:0];
        RXHDR1_OFS: r_next.prdata = r_reg.hdr[63:32];
        RXHDR2_OFS: r_next.prdata = {16'h0000, r_reg.hdr[79:64]};
        RXOCT_OFS: r_next.prdata[BUSY_POS] = r_reg.rx_busy;
        TXOCT_OFS: r_next.prdata = {8'h00, r_reg.tx_count, r_reg.tx_last};
        TXINFO_OFS: r_next.prdata = {1'b0, r_reg.txv.band_group_code, r_reg.txv.time_freq_code,
                                     r_reg.txv.tx_power, r_reg.txv.scrambler, r_reg.txv.pre_type,
                                     r_reg.txv.burst, r_reg.txv.rate, r_reg.txv.length};
        default: r_next.pslverr = 1'b1;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg <= '0;
      r_reg.state <= ST_IDLE;
      r_reg.rxinfo <= RXINFO_RST;
      r_reg.rxqual <= RXQUAL_RST;
      r_reg.hdr <= HDR_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  // ==========================================================================
  // Outputs
  assign phy = r_reg.phy;
  // Zero wait states: every access cycle completes
  assign apb_rsp = '{pready: 1'b1, prdata: r_reg.prdata, pslverr: r_reg.pslverr};

  // ==========================================================================
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  tx_start_cfm_a: assert property (
    r_reg.state == ST_TX_PRE && ev[EV_PRE_SENT] |=> phy.tx_start_cfm ##1 !phy.tx_start_cfm)
    else $error("transmit start confirm missing");

  tx_end_cfm_a: assert property (
    r_reg.state == ST_TX_DATA && mac.tx_end_req |=> phy.tx_end_cfm && r_reg.state == ST_IDLE)
    else $error("transmit end confirm missing");

  rx_end_cfm_a: assert property (
    in_rx && mac.rx_end_req |=> phy.rx_end_cfm && r_reg.state == ST_IDLE && !r_reg.rx_busy)
    else $error("receive end confirm missing");

  sync_pulse_a: assert property (
    phy.rx_sync_ind |-> $past(r_reg.state) == ST_RX_ACQ && r_reg.state == ST_RX_HDR)
    else $error("sync indication out of place");

  octet_tx_cfm_a: assert property (
    phy.octet_tx_cfm |-> $past(r_reg.state) == ST_TX_DATA && r_reg.tx_last == $past(mac.octet_tx_data))
    else $error("octet confirm outside transmit or wrong data");

  rx_ind_gap_a: assert property (
    phy.octet_rx_ind ##1 !mac.octet_rx_rsp |=> !phy.octet_rx_ind)
    else $error("octet indication before response");

  herr_bits_a: assert property (
    phy.rx_start_cfm |-> phy.rx_param_vector.header_error[7:5] == 3'h0
      && phy.rx_param_vector.header_error[1:0] == 2'h0)
    else $error("header error uses undefined bits");

  pre_reserved_a: assert property (
    phy.rx_start_cfm && !phy.rx_param_vector.burst |-> !phy.rx_param_vector.pre_type)
    else $error("preamble type set outside burst mode");

  rx_cfm_then_data_a: assert property (
    phy.rx_start_cfm |-> r_reg.state == ST_RX_DATA && $past(r_reg.state) != ST_RX_DATA)
    else $error("receive confirm without state change");

  tx_enter_a: assert property (
    r_reg.state == ST_IDLE && mac.tx_start_req |=> r_reg.state == ST_TX_PRE
      && r_reg.txv == $past(mac.tx_param_vector))
    else $error("transmit start not taken");

  rx_enter_a: assert property (
    r_reg.state == ST_IDLE && !mac.tx_start_req && mac.rx_start_req |=> r_reg.state == ST_RX_ACQ)
    else $error("receive start not taken");

  start_cfm_gate_a: assert property (
    phy.tx_start_cfm |-> $past(r_reg.state) == ST_TX_PRE && r_reg.state == ST_TX_DATA)
    else $error("start confirm out of place");

  tx_end_gate_a: assert property (
    r_reg.state != ST_TX_DATA |=> !phy.tx_end_cfm)
    else $error("end confirm outside transmit");

  octet_count_a: assert property (
    r_reg.state == ST_TX_DATA && mac.octet_tx_req |=> phy.octet_tx_cfm
      && r_reg.tx_count == $past(r_reg.tx_count) + 16'h0001)
    else $error("octet not confirmed or counted");

  octet_tx_gate_a: assert property (
    r_reg.state != ST_TX_DATA |=> !phy.octet_tx_cfm)
    else $error("octet confirm outside transmit");

  sync_cause_a: assert property (
    r_reg.state == ST_RX_ACQ && ev[EV_SYNC] |=> phy.rx_sync_ind)
    else $error("sync indication missing");

  hdr_cfm_a: assert property (
    r_reg.state == ST_RX_HDR && ev[EV_HDR_DONE] |=> phy.rx_start_cfm && phy.rx_param_vector == $past(rx_vec))
    else $error("receive confirm missing");

  timeout_len_a: assert property (
    rx_timeout |=> phy.rx_start_cfm && phy.rx_param_vector.length == 12'h000)
    else $error("timeout reports a length");

  herr_map_a: assert property (
    phy.rx_start_cfm |-> phy.rx_param_vector.header_error[HERR_CHK_BIT:HERR_CHAN_BIT]
      == {$past(r_reg.rxqual[0]), $past(r_reg.rxqual[1]), $past(r_reg.rxqual[2])})
    else $error("header error bits misplaced");

  vec_codes_a: assert property (
    phy.rx_start_cfm |-> phy.rx_param_vector.rate == $past(r_reg.rxinfo[16:12])
      && phy.rx_param_vector.burst == $past(r_reg.rxinfo[17])
      && phy.rx_param_vector.time_freq_code == $past(r_reg.rxinfo[22:19])
      && phy.rx_param_vector.band_group_code == $past(r_reg.rxinfo[25:23]))
    else $error("vector codes misplaced");

  quality_map_a: assert property (
    phy.rx_start_cfm |-> phy.rx_param_vector.signal_strength == $past(r_reg.rxqual[15:8])
      && phy.rx_param_vector.link_quality == $past(r_reg.rxqual[23:16]))
    else $error("quality fields misplaced");

  header_copy_a: assert property (
    phy.rx_start_cfm |-> phy.rx_param_vector.frame_header_copy == $past(r_reg.hdr))
    else $error("header copy differs");

  rx_ind_gate_a: assert property (
    phy.octet_rx_ind |-> $past(r_reg.state) == ST_RX_DATA && !$past(r_reg.rx_busy)
      && phy.octet_rx_data == $past(apb_req.pwdata[7:0]))
    else $error("octet indication misplaced");

  busy_clear_a: assert property (
    mac.octet_rx_rsp |=> !r_reg.rx_busy)
    else $error("busy kept after response");

  push_refused_a: assert property (
    rx_refused |=> st_q[6])
    else $error("refused push not flagged");

  done_ind_a: assert property (
    r_reg.state == ST_RX_DATA && ev[EV_PKT_DONE] |=> phy.rx_done_ind)
    else $error("done indication missing");

  done_gate_a: assert property (
    phy.rx_done_ind |-> $past(r_reg.state) == ST_RX_DATA)
    else $error("done indication misplaced");

  rx_end_gate_a: assert property (
    !in_rx |=> !phy.rx_end_cfm)
    else $error("end confirm outside reception");

  idle_quiet_a: assert property (
    r_reg.state == ST_IDLE |=> !phy.tx_start_cfm && !phy.tx_end_cfm && !phy.rx_start_cfm && !phy.rx_sync_ind
      && !phy.rx_done_ind && !phy.rx_end_cfm && !phy.octet_tx_cfm && !phy.octet_rx_ind)
    else $error("strobe raised while idle");

endmodule : usc_core

// file: usc_pkg.sv
/*
  Shared types and constants of the service sequencer that sits on the
  physical-layer side of the link to the medium access controller.
  Assumes one clock for the controller, this block and the APB master.
*/
// What this block does
// - On transmit-start, send preamble, then confirm the start of packet transmission.
// - On transmit-end request, stop transmitting, then return transmit-end confirm; code acts on it only in ST_TX_DATA and ignores it in ST_TX_PRE.
// - On receive-start, begin preamble acquisition; later answer with receive-start confirm.
// - Pulse sync indication at end of preamble synchronisation; marks frame start.
// - Return receive-start confirm with vector after whole header or a timeout.
// - Header error is 8 bits; bit 4 checksum, bit 3 rate, bit 2 channel.
// - On receive-end request, stop receiving and issue the end confirm.
// - Length counts payload octets; 0..max standard, 1..max burst.
// - Receive vector reports the body data rate as a 5-bit code.
// - Burst flag zero is standard mode, one means another packet follows.
// - Preamble type selects standard or burst; reserved zero when burst flag clear.
// - Receive vector carries 4-bit time-frequency code and 3-bit band group code.
// - Receive vector delivers the 10-octet frame header copy.
// - Signal strength in decibels from 0, rising with received power.
// - Link quality is 8 bits, rising with assessed link quality.
// - Transmit octets only after start confirm; each octet confirmed before next.
// - Receive octets only after receive confirm; each answered before the next.
// - Pulse a receive-done indication when the complete packet is received.
package usc_pkg;

  // ==========================================================================
  // Register map (byte addresses)
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] RXINFO_OFS = 8'h08;
  localparam logic [7:0] RXQUAL_OFS = 8'h0c;
  localparam logic [7:0] RXHDR0_OFS = 8'h10;
  localparam logic [7:0] RXHDR1_OFS = 8'h14;
  localparam logic [7:0] RXHDR2_OFS = 8'h18;
  localparam logic [7:0] RXOCT_OFS = 8'h1c;
  localparam logic [7:0] TXOCT_OFS = 8'h20;
  localparam logic [7:0] TXINFO_OFS = 8'h24;

  // ==========================================================================
  // Field positions
  localparam int EV_PRE_SENT = 0;
  localparam int EV_SYNC = 1;
  localparam int EV_HDR_DONE = 2;
  localparam int EV_TIMEOUT = 3;
  localparam int EV_PKT_DONE = 4;
  localparam int HERR_CHK_BIT = 4;
  localparam int HERR_RATE_BIT = 3;
  localparam int HERR_CHAN_BIT = 2;
  localparam int ST_W = 7;
  localparam int STATE_POS = 8;
  localparam int BUSY_POS = 11;
  localparam int CNT_POS = 8;

  // ==========================================================================
  // Reset values
  localparam logic [31:0] RXINFO_RST = 32'h0000_0000;
  localparam logic [23:0] RXQUAL_RST = 24'h00_0000;
  localparam logic [79:0] HDR_RST = 80'h0;

  // ==========================================================================
  // Types
  typedef enum logic [2:0] {
    ST_IDLE, ST_TX_PRE, ST_TX_DATA, ST_RX_ACQ, ST_RX_HDR, ST_RX_DATA
  } usc_state_e;

  typedef struct packed {
    logic [11:0] length;
    logic [4:0] rate;
    logic burst;
    logic pre_type;
    logic [1:0] scrambler;
    logic [2:0] tx_power;
    logic [3:0] time_freq_code;
    logic [2:0] band_group_code;
    logic [79:0] frame_header_copy;
  } usc_txv_s;

  typedef struct packed {
    logic [11:0] length;
    logic [4:0] rate;
    logic burst;
    logic pre_type;
    logic [3:0] time_freq_code;
    logic [2:0] band_group_code;
    logic [79:0] frame_header_copy;
    logic [7:0] header_error;
    logic [7:0] signal_strength;
    logic [7:0] link_quality;
  } usc_rxv_s;

  typedef struct packed {
    logic tx_start_req;
    usc_txv_s tx_param_vector;
    logic tx_end_req;
    logic rx_start_req;
    logic rx_end_req;
    logic octet_tx_req;
    logic [7:0] octet_tx_data;
    logic octet_rx_rsp;
  } usc_mac_s;

  typedef struct packed {
    logic tx_start_cfm;
    logic tx_end_cfm;
    logic rx_start_cfm;
    usc_rxv_s rx_param_vector;
    logic rx_sync_ind;
    logic rx_done_ind;
    logic rx_end_cfm;
    logic octet_tx_cfm;
    logic octet_rx_ind;
    logic [7:0] octet_rx_data;
  } usc_phy_s;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } usc_apb_req_s;

  typedef struct packed {
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } usc_apb_rsp_s;

  typedef struct packed {
    usc_state_e state;
    usc_phy_s phy;
    logic [31:0] rxinfo;
    logic [23:0] rxqual;
    logic [79:0] hdr;
    usc_txv_s txv;
    logic [7:0] tx_last;
    logic [15:0] tx_count;
    logic rx_busy;
    logic [31:0] prdata;
    logic pslverr;
  } usc_core_s;

endpackage : usc_pkg

// file: usc_sticky.sv
/*
  Sticky status bits, write-one-to-clear.
  Assumes set and clear strobes come from the same clock domain.
*/
`timescale 1ns/1ps
module usc_sticky #(
  parameter int W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] set,
  input wire logic [W-1:0] clr,
  output logic [W-1:0] q
);
  logic [W-1:0] q_reg;
  logic [W-1:0] q_next;

  // A set in the clearing cycle wins
  always_comb begin
    q_next = (q_reg & ~clr) | set;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_reg <= '0;
    end else begin
      q_reg <= q_next;
    end
  end

  assign q = q_reg;
endmodule : usc_sticky

// file: usc_rxv_pack.sv
/*
  Builds the receive parameter vector from the values the modem firmware
  loaded. Assumes inputs are stable register contents.
*/
`timescale 1ns/1ps
module usc_rxv_pack (
  input wire logic [31:0] rxinfo,
  input wire logic [23:0] rxqual,
  input wire logic [79:0] hdr,
  input wire logic timeout,
  output usc_pkg::usc_rxv_s vec
);
  import usc_pkg::*;

  always_comb begin
    vec = '0;
    // A timed-out header reports no payload
    vec.length = timeout ? 12'h000 : rxinfo[11:0];
    vec.rate = rxinfo[16:12];
    vec.burst = rxinfo[17];
    vec.pre_type = rxinfo[17] & rxinfo[18];
    vec.time_freq_code = rxinfo[22:19];
    vec.band_group_code = rxinfo[25:23];
    vec.frame_header_copy = hdr;
    vec.header_error[HERR_CHK_BIT] = rxqual[0];
    vec.header_error[HERR_RATE_BIT] = rxqual[1];
    vec.header_error[HERR_CHAN_BIT] = rxqual[2];
    vec.signal_strength = rxqual[15:8];
    vec.link_quality = rxqual[23:16];
  end
endmodule : usc_rxv_pack

// file: usc_mac_model.sv
/*
  Behavioural model of the medium access controller facing the service
  sequencer: one-cycle request strobes, confirm waits, octet responses.
  Assumes it shares pclk and presetn with the sequencer.
*/
`timescale 1ns/1ps
module usc_mac_model
  import usc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input usc_pkg::usc_phy_s phy,
  output usc_pkg::usc_mac_s mac
);
  logic [4:0] strobe = '0;
  logic rsp;
  logic pend;
  usc_txv_s txv = '0;
  logic [7:0] od = '0;
  int rsp_delay = 0;
  int cnt;
  usc_rxv_s rxv;
  logic [7:0] rx_octet;
  logic [7:0] ev;

  // ==========================================================================
  // Strobes towards the sequencer
  assign mac = '{tx_start_req: strobe[0], tx_param_vector: txv, tx_end_req: strobe[1],
                 rx_start_req: strobe[2], rx_end_req: strobe[3], octet_tx_req: strobe[4],
                 octet_tx_data: od, octet_rx_rsp: rsp};
  assign ev = {phy.octet_rx_ind, phy.octet_tx_cfm, phy.rx_end_cfm, phy.rx_done_ind,
               phy.rx_sync_ind, phy.rx_start_cfm, phy.tx_end_cfm, phy.tx_start_cfm};

  task automatic pulse(input int k);
    @(posedge pclk);
    strobe[k] <= 1'b1;
    @(posedge pclk);
    strobe[k] <= 1'b0;
  endtask : pulse

  task automatic wait_ev(input int k);
    int i;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (ev[k] !== 1'b1 && i < 60);
  endtask : wait_ev

  task automatic tx_start(input usc_txv_s v);
    @(posedge pclk);
    txv <= v;
    strobe[0] <= 1'b1;
    @(posedge pclk);
    strobe[0] <= 1'b0;
  endtask : tx_start

  // Next octet only after the previous one is confirmed
  task automatic send_octet(input logic [7:0] d);
    @(posedge pclk);
    od <= d;
    strobe[4] <= 1'b1;
    @(posedge pclk);
    strobe[4] <= 1'b0;
    wait_ev(6);
  endtask : send_octet

  // Nothing new is started until the end confirm arrives
  task automatic tx_end();
    pulse(1);
    wait_ev(1);
  endtask : tx_end

  task automatic rx_end();
    pulse(3);
    wait_ev(5);
  endtask : rx_end

  // ==========================================================================
  // Octet responses and vector capture
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rsp <= 1'b0;
      pend <= 1'b0;
      cnt <= 0;
    end else begin
      rsp <= 1'b0;
      if (ev[7]) begin
        pend <= 1'b1;
        cnt <= rsp_delay;
        rx_octet <= phy.octet_rx_data;
      end else if (pend) begin
        if (cnt == 0) begin
          rsp <= 1'b1;
          pend <= 1'b0;
        end else begin
          cnt <= cnt - 1;
        end
      end
      if (ev[2]) begin
        rxv <= phy.rx_param_vector;
      end
    end
  end
endmodule : usc_mac_model

// file: usc_core_tb.sv
/*
  Self-checking bench of the service sequencer: APB master tasks, the
  controller model, strobe counters and directed sequences.
  Assumes usc_pkg, usc_core and usc_mac_model are compiled first.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; \
  $display("FAIL %s expected %0h seen %0h", nm, e, g); end end
module usc_core_tb;
  import usc_pkg::*;
  localparam logic [79:0] HDR = 80'h9a8b_7c6d_5e4f_3021_1203;
  logic pclk;
  logic presetn;
  usc_apb_req_s apb_req;
  usc_apb_rsp_s apb_rsp;
  usc_mac_s mac;
  usc_phy_s phy;
  int n_mismatch = 0;
  int samples_checked = 0;
  int cycles = 0;
  int n_ev[8] = '{default: 0};
  logic [31:0] rd;
  logic err;
  usc_txv_s tv;

  usc_core usc_core_i (.pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
                       .mac(mac), .phy(phy));
  usc_mac_model mac_m (.pclk(pclk), .presetn(presetn), .phy(phy), .mac(mac));

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // ==========================================================================
  // Strobe counters and hang guard
  always @(posedge pclk) begin
    cycles++;
    for (int k = 0; k < 8; k++) n_ev[k] += int'(mac_m.ev[k] === 1'b1);
    if (cycles == 5000) begin
      n_mismatch++;
      conclude();
    end
  end

  task conclude;
    if (n_mismatch == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : conclude

  // ==========================================================================
  // APB access
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
    @(posedge pclk);
    apb_req.penable <= 1'b1;
    do @(posedge pclk); while (apb_rsp.pready !== 1'b1);
    rd = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask : apb

  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(nm, e, rd & m)
  endtask : rdc

  task automatic settle();
    repeat (3) @(posedge pclk);
  endtask : settle

  // Loads the header results, runs acquisition and checks the vector
  task automatic rx_hdr(input logic [31:0] info, input logic [23:0] q, input logic [4:0] evb);
    usc_rxv_s e;
    int n;
    int ns;
    n = n_ev[2];
    ns = n_ev[3];
    e = '{length: evb[3] ? 12'h0 : info[11:0], rate: info[16:12], burst: info[17],
          pre_type: info[17] & info[18], time_freq_code: info[22:19], band_group_code: info[25:23],
          frame_header_copy: HDR, header_error: {3'b0, q[0], q[1], q[2], 2'b0},
          signal_strength: q[15:8], link_quality: q[23:16]};
    apb(1'b1, RXINFO_OFS, info);
    apb(1'b1, RXQUAL_OFS, {8'h0, q});
    mac_m.pulse(2);
    apb(1'b1, CTRL_OFS, 32'h2);
    apb(1'b1, CTRL_OFS, {27'h0, evb});
    settle();
    `CHK("rx_sync_ind", ns + 1, n_ev[3])
    `CHK("rx_start_cfm", n + 1, n_ev[2])
    `CHK("rx_vector", e, mac_m.rxv)
  endtask : rx_hdr

  // ==========================================================================
  // Sequences
  initial begin
    apb_req = '0;
    presetn = 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rdc("status_rst", STATUS_OFS, 32'hfff, 32'h0);
    rdc("rxinfo_rst", RXINFO_OFS, 32'hffffffff, RXINFO_RST);
    apb(1'b0, 8'h30, 32'h0);
    `CHK("unmapped_err", 1'b1, err)
    mac_m.pulse(1);
    mac_m.pulse(3);
    apb(1'b1, CTRL_OFS, 32'h1f);
    settle();
    for (int k = 0; k < 8; k++) `CHK("idle_strobe", 0, n_ev[k])
    rdc("status_refused", STATUS_OFS, 32'hfff, 32'h0a);
    apb(1'b1, STATUS_OFS, 32'h7f);
    rdc("status_clear", STATUS_OFS, 32'h7f, 32'h0);
    // Transmit
    tv = '{length: 12'h3, rate: 5'h0b, burst: 1'b1, pre_type: 1'b1, scrambler: 2'h2, tx_power: 3'h5,
           time_freq_code: 4'h9, band_group_code: 3'h6, frame_header_copy: HDR};
    mac_m.tx_start(tv);
    rdc("tx_preamble_state", STATUS_OFS, 32'h700, 32'h100);
    `CHK("tx_start_early", 0, n_ev[0])
    rdc("txinfo", TXINFO_OFS, 32'h7fffffff, {1'b0, 3'h6, 4'h9, 3'h5, 2'h2, 1'b1, 1'b1, 5'h0b, 12'h3});
    apb(1'b1, CTRL_OFS, 32'h1);
    settle();
    `CHK("tx_start_cfm", 1, n_ev[0])
    for (int i = 0; i < 3; i++) mac_m.send_octet(8'ha0 + 8'(i));
    settle();
    `CHK("octet_tx_cfm", 3, n_ev[6])
    rdc("txoct", TXOCT_OFS, 32'hffffff, {16'h3, 8'ha2});
    mac_m.tx_end();
    settle();
    `CHK("tx_end_cfm", 1, n_ev[1])
    rdc("tx_idle", STATUS_OFS, 32'h700, 32'h0);
    // Receive with a valid burst header
    apb(1'b1, RXHDR0_OFS, HDR[31:0]);
    apb(1'b1, RXHDR1_OFS, HDR[63:32]);
    apb(1'b1, RXHDR2_OFS, {16'h0, HDR[79:64]});
    mac_m.rsp_delay = 3;
    rx_hdr({6'h0, 3'h3, 4'h5, 1'b1, 1'b1, 5'h0d, 12'h1}, 24'hc83c00, 5'h04);
    rdc("rx_data_state", STATUS_OFS, 32'h700, 32'h500);
    apb(1'b1, RXOCT_OFS, 32'h5a);
    apb(1'b1, RXOCT_OFS, 32'ha5);
    settle();
    `CHK("octet_rx_ind", 1, n_ev[7])
    `CHK("octet_rx_data", 8'h5a, mac_m.rx_octet)
    rdc("push_refused", STATUS_OFS, 32'h40, 32'h40);
    apb(1'b1, RXOCT_OFS, 32'ha5);
    repeat (8) @(posedge pclk);
    `CHK("octet_rx_ind2", 2, n_ev[7])
    `CHK("octet_rx_data2", 8'ha5, mac_m.rx_octet)
    apb(1'b1, CTRL_OFS, 32'h10);
    settle();
    `CHK("rx_done_ind", 1, n_ev[4])
    mac_m.rx_end();
    settle();
    `CHK("rx_end_cfm", 1, n_ev[5])
    // Header faults, one flag at a time, then a timeout with all flags
    for (int i = 0; i < 3; i++) begin
      rx_hdr(32'h0004_0005, 24'h1 << i, 5'h04);
      mac_m.rx_end();
    end
    rx_hdr(32'h0000_0005, 24'h7, 5'h08);
    mac_m.rx_end();
    settle();
    `CHK("rx_end_cfm_all", 5, n_ev[5])
    rdc("rx_idle", STATUS_OFS, 32'hf00, 32'h0);
    conclude();
  end
endmodule : usc_core_tb
